// ===== core/uart_text_capture_monitor.v
// Receive-only serial text capture monitor with its line buffer
`timescale 1ns/1ps
`include "uart_capture_map.vh"

// Small synchronous FIFO with valid/ready on both sides
// Pointers wrap naturally at the power-of-two depth; the fill count
// is one bit wider so full and empty stay distinct.
// Read data is the head word, shown while out_valid_o is high.
module cap_fifo #(
   parameter WIDTH = `CAP_DATA_WIDTH,
   parameter DEPTH = `CAP_FIFO_DEPTH,
   parameter AW = `CAP_FIFO_AW
) (
   input wire core_clk_i,            // Clock
   input wire nrst_i,                // Async reset, active low
   input wire in_valid_i,            // Write request
   output wire in_ready_o,           // Space available
   input wire [WIDTH-1:0] in_data_i, // Write data
   output wire out_valid_o,          // Data available
   input wire out_ready_i,           // Read accept
   output wire [WIDTH-1:0] out_data_o, // Head word
   output wire [AW:0] level_o        // Words held
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign level_o = count;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;

   // Storage array, no reset needed
   always @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and fill count
   // Simultaneous push and pop leave the count unchanged
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // cap_fifo

// Top: samples the line, frames characters, buffers lines, ends the run
module uart_text_capture_monitor (
   input wire core_clk_i,            // Clock, equal to the bit rate
   input wire nrst_i,                // Async reset, active low
   input wire serial_i,              // Transmit line of the UART
   output wire text_valid_o,         // Released character available
   input wire text_ready_i,          // Consumer takes character
   output wire [7:0] text_char_o,    // Released character
   output wire text_eol_o,           // Character is the closing CR
   output reg sim_finish_pulse_o,    // One-cycle end-of-run pulse
   output reg sim_halt_o,            // Run halted, level
   output reg overflow_o,            // Character dropped, pulse
   output reg frame_err_o            // Bad stop bit, pulse
);
   reg line_s1;
   reg line_s2;
   reg [1:0] state;
   reg [2:0] bit_idx;
   reg [7:0] shreg;
   reg esc_prev;
   reg [`CAP_FIFO_AW:0] lines_pending;
   wire rx_done;
   wire is_cr;
   wire is_eot;
   wire end_run;
   wire fifo_in_ready;
   wire [`CAP_FIFO_AW:0] fifo_level;
   wire room_ok;
   wire wr_en;
   wire fifo_out_valid;
   wire pop;

   // Timing from pin to text, in clock cycles (one cycle is one bit):
   // the line passes two synchroniser flops, so the receiver sees a
   // start bit two cycles late; the character is written at the edge
   // that samples its stop bit, and a closing CR makes the line
   // visible at that same edge. Receiving stops for good after an
   // unescaped end character, so a stray frame cannot reopen the run.

   // Two-flop synchroniser on the serial pin
   // Both flops reset to the idle level so release sees no start bit
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         line_s1 <= `CAP_LINE_IDLE;
         line_s2 <= `CAP_LINE_IDLE;
      end else begin
         line_s1 <= serial_i;
         line_s2 <= line_s1;
      end
   end

   // Receiver, one sample per clock, stops once the run is ended
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= `CAP_ST_IDLE;
         bit_idx <= `CAP_FIRST_BIT;
         shreg <= `CAP_SHREG_CLEAR;
      end else begin
         case (state)
            `CAP_ST_IDLE: begin
               // Low start bit opens a frame
               if (!line_s2 && !sim_finish_pulse_o && !sim_halt_o) begin
                  state <= `CAP_ST_DATA;
                  bit_idx <= `CAP_FIRST_BIT;
               end
            end
            `CAP_ST_DATA: begin
               // LSB first, one bit every cycle
               shreg <= {line_s2, shreg[7:1]};
               bit_idx <= bit_idx + 1'b1;
               if (bit_idx == `CAP_LAST_BIT) begin
                  state <= `CAP_ST_STOP;
               end
            end
            `CAP_ST_STOP: begin
               state <= `CAP_ST_IDLE;
            end
            default: begin
               state <= `CAP_ST_IDLE;
            end
         endcase
      end
   end

   // Valid character when the stop bit is high
   assign rx_done = (state == `CAP_ST_STOP) & line_s2;
   assign is_cr = (shreg == `CAP_CHAR_CR);
   assign is_eot = (shreg == `CAP_CHAR_EOT);
   // Terminate unless escaped
   assign end_run = rx_done & is_eot & ~esc_prev;

   // Keep one slot free for CR so a full buffer cannot lock up
   // A dropped character raises overflow_o for one cycle
   assign room_ok = is_cr ? fifo_in_ready :
      (fifo_level < (`CAP_FIFO_DEPTH - 1));
   assign wr_en = rx_done & ~end_run & room_ok;

   // Escape tracking, finish pulse, halt and error pulses
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         esc_prev <= 1'b0;
         sim_finish_pulse_o <= 1'b0;
         sim_halt_o <= 1'b0;
         overflow_o <= 1'b0;
         frame_err_o <= 1'b0;
      end else begin
         // Any good character re-arms or clears the escape, so only
         // the character directly after an escape is protected
         if (rx_done) begin
            esc_prev <= (shreg == `CAP_CHAR_ESC);
         end
         sim_finish_pulse_o <= end_run;
         if (sim_finish_pulse_o) begin
            sim_halt_o <= 1'b1; // Halt follows the pulse
         end
         overflow_o <= rx_done & ~end_run & ~room_ok;
         frame_err_o <= (state == `CAP_ST_STOP) & ~line_s2;
      end
   end

   // Line buffer
   cap_fifo #(
      .WIDTH(`CAP_DATA_WIDTH),
      .DEPTH(`CAP_FIFO_DEPTH),
      .AW(`CAP_FIFO_AW)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(wr_en),
      .in_ready_o(fifo_in_ready),
      .in_data_i(shreg),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop),
      .out_data_o(text_char_o),
      .level_o(fifo_level)
   );

   // Release text only while a completed line is held
   // Characters of an unfinished line wait behind the last CR
   assign text_valid_o = fifo_out_valid &
      (lines_pending != {(`CAP_FIFO_AW+1){1'b0}});
   assign pop = text_valid_o & text_ready_i;
   assign text_eol_o = text_valid_o & (text_char_o == `CAP_CHAR_CR);

   // Count of CRs in the buffer; arrival and release together cancel
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lines_pending <= {(`CAP_FIFO_AW+1){1'b0}};
      end else begin
         if ((wr_en & is_cr) & ~(pop & text_eol_o)) begin
            lines_pending <= lines_pending + 1'b1;
         end else if (~(wr_en & is_cr) & (pop & text_eol_o)) begin
            lines_pending <= lines_pending - 1'b1;
         end
      end
   end
endmodule // uart_text_capture_monitor

// ===== core/uart_capture_map.vh
// Constants for the serial text capture monitor
// Overview of operation
// - The monitor samples the serial line once per clock, one bit a cycle.
// - Received characters are held and only released once a CR arrives.
// - A received 0x04 ends the run, unless the escape case applies.
// - A 0x04 that directly follows an 0x1B escape does not end the run.
// - A one-cycle finish pulse is driven before the halt takes effect.
`ifndef UART_CAPTURE_MAP_VH
`define UART_CAPTURE_MAP_VH

// Special character codes
`define CAP_CHAR_CR 8'h0D
`define CAP_CHAR_EOT 8'h04
`define CAP_CHAR_ESC 8'h1B

// Frame shape
`define CAP_DATA_WIDTH 8
`define CAP_LAST_BIT 3'h7
`define CAP_FIRST_BIT 3'h0

// Text buffer shape
`define CAP_FIFO_DEPTH 8
`define CAP_FIFO_AW 3

// Line idle level and shift register clear value at reset
`define CAP_LINE_IDLE 1'h1
`define CAP_SHREG_CLEAR 8'h00

// Receiver states
`define CAP_ST_IDLE 2'h0
`define CAP_ST_DATA 2'h1
`define CAP_ST_STOP 2'h2

`endif

// ===== tb/uart_tx_model.sv
// Serial transmitter model, one bit per clock
`timescale 1ns/1ps
module uart_tx_model (
   input wire clk_i, // Bit clock
   output reg line_o // Serial line, idle high
);
   initial line_o = 1'b1;
   // One frame; stop bit stays as the idle level
   task send(input [7:0] c);
      reg [9:0] f;
      integer i;
      begin
         f = {1'b1, c, 1'b0};
         for (i = 0; i < 10; i = i + 1) begin
            @(negedge clk_i);
            line_o = f[i];
         end
      end
   endtask
   // One frame with a low stop bit, then the line back to idle
   task send_bad(input [7:0] c);
      reg [9:0] g;
      integer k;
      begin
         g = {1'b0, c, 1'b0};
         for (k = 0; k < 10; k = k + 1) begin
            @(negedge clk_i);
            line_o = g[k];
         end
         @(negedge clk_i);
         line_o = 1'b1;
      end
   endtask
endmodule // uart_tx_model

// ===== tb/uart_text_capture_monitor_sva.sv
// Port assertions for the serial text capture monitor
`timescale 1ns/1ps
module cap_mon_sva (
   input wire core_clk_i, // Clock
   input wire nrst_i, // Reset
   input wire serial_i, // Line
   input wire text_valid_o, // Valid
   input wire text_ready_i, // Ready
   input wire [7:0] text_char_o, // Char
   input wire text_eol_o, // CR flag
   input wire sim_finish_pulse_o, // Finish
   input wire sim_halt_o, // Halt
   input wire overflow_o, // Drop
   input wire frame_err_o // Bad stop
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   AST_PULSE_ONE: assert property (
      sim_finish_pulse_o |=> !sim_finish_pulse_o)
      else $error("finish pulse too long");
   AST_PULSE_FIRST: assert property (
      sim_finish_pulse_o |-> !sim_halt_o ##1 sim_halt_o)
      else $error("halt not right after pulse");
   AST_HALT_STAYS: assert property (
      sim_halt_o |=> sim_halt_o && !sim_finish_pulse_o)
      else $error("halt dropped or pulse repeated");
   AST_EOL_CR: assert property (
      text_valid_o && text_eol_o |-> text_char_o == 8'h0D)
      else $error("line end flag on non CR");
   AST_TEXT_HOLD: assert property (
      text_valid_o && !text_ready_i |=> text_valid_o && $stable(text_char_o))
      else $error("text changed while not taken");
   AST_FIN_FRAME: assert property (
      sim_finish_pulse_o |-> $past(serial_i, 3) && $past(serial_i, 9)
         && !$past(serial_i, 12) && !$past(serial_i, 11))
      else $error("finish without an end character frame");
   AST_ERR_ONE: assert property (
      frame_err_o |=> !frame_err_o)
      else $error("frame error pulse too long");
endmodule // cap_mon_sva
bind uart_text_capture_monitor cap_mon_sva chk (
   .core_clk_i(core_clk_i),
   .nrst_i(nrst_i),
   .serial_i(serial_i),
   .text_valid_o(text_valid_o),
   .text_ready_i(text_ready_i),
   .text_char_o(text_char_o),
   .text_eol_o(text_eol_o),
   .sim_finish_pulse_o(sim_finish_pulse_o),
   .sim_halt_o(sim_halt_o),
   .overflow_o(overflow_o),
   .frame_err_o(frame_err_o)
);

// ===== tb/tb_uart_text_capture_monitor.sv
// Bench for the serial text capture monitor
`timescale 1ns/1ps
module tb_uart_text_capture_monitor;
   reg core_clk_i = 1'b0;
   reg nrst_i = 1'b0;
   reg text_ready_i = 1'b0;
   wire serial, tv, eol, fin, halt, ovf, ferr;
   wire [7:0] ch;
   integer num_errors = 0;
   integer checked = 0;
   integer cyc = 0;
   integer nfin = 0;
   integer novf = 0;
   integer nferr = 0;
   integer i;
   always #4 core_clk_i = ~core_clk_i;
   uart_tx_model tx (.clk_i(core_clk_i), .line_o(serial));
   uart_text_capture_monitor dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .serial_i(serial), .text_valid_o(tv), .text_ready_i(text_ready_i),
      .text_char_o(ch), .text_eol_o(eol), .sim_finish_pulse_o(fin),
      .sim_halt_o(halt), .overflow_o(ovf), .frame_err_o(ferr));
   task results;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [8*5:1] nm, input [9:0] exp, input [9:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %0s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   // Waits for a released char, checks it, takes it
   task pop(input [7:0] c);
      integer n;
      begin
         n = 0;
         @(negedge core_clk_i);
         while (tv !== 1'b1 && n < 60) begin
            @(negedge core_clk_i);
            n = n + 1;
         end
         chk("char", {1'b1, c == 8'h0D, c}, {tv, eol, ch});
         text_ready_i = 1'b1;
         @(negedge core_clk_i);
         text_ready_i = 1'b0;
      end
   endtask
   // Pulse and overflow counters, run limit
   always @(posedge core_clk_i) begin
      cyc = cyc + 1;
      if (fin === 1'b1) nfin = nfin + 1;
      if (ovf === 1'b1) novf = novf + 1;
      if (ferr === 1'b1) nferr = nferr + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         results;
      end
   end
   task t_line;
      begin
         tx.send(8'h48);
         tx.send(8'h69);
         repeat (6) @(negedge core_clk_i);
         chk("wait", 10'h000, {9'h000, tv});
         tx.send(8'h0D);
         pop(8'h48);
         pop(8'h69);
         pop(8'h0D);
      end
   endtask
   task t_esc;
      begin
         tx.send(8'h1B);
         tx.send(8'h04);
         tx.send(8'h0D);
         pop(8'h1B);
         pop(8'h04);
         pop(8'h0D);
         chk("nfin", 10'h000, nfin[9:0]);
      end
   endtask
   task t_fill;
      begin
         for (i = 0; i < 8; i = i + 1) tx.send(8'h61 + i[7:0]);
         tx.send(8'h0D);
         for (i = 0; i < 7; i = i + 1) pop(8'h61 + i[7:0]);
         pop(8'h0D);
         chk("novf", 10'h001, novf[9:0]);
      end
   endtask
   // Low stop bit: character dropped, error pulse, next line intact
   task t_ferr;
      begin
         tx.send_bad(8'h41);
         tx.send(8'h0D);
         pop(8'h0D);
         chk("nferr", 10'h001, nferr[9:0]);
      end
   endtask
   task t_end;
      begin
         // Escape cleared by an ordinary character, so the end counts
         tx.send(8'h1B);
         tx.send(8'h41);
         tx.send(8'h04);
         repeat (6) @(negedge core_clk_i);
         chk("nfin", 10'h001, nfin[9:0]);
         chk("halt", 10'h001, {9'h000, halt});
         tx.send(8'h41);
         tx.send(8'h0D);
         repeat (8) @(negedge core_clk_i);
         chk("idle", 10'h000, {9'h000, tv});
      end
   endtask
   initial begin
      repeat (5) @(negedge core_clk_i);
      nrst_i = 1'b1;
      t_line;
      t_esc;
      t_fill;
      t_ferr;
      t_end;
      results;
   end
endmodule // tb_uart_text_capture_monitor
